// >>> hw/power_mode_pkg.sv
// Shared constants and types for the power mode control block
package power_mode_pkg;
  localparam int ADDR_W = 16;
  localparam logic [15:0] SYSCTL_ONE_ADDR = 16'hFFF0;
  localparam logic [15:0] SYSCTL_TWO_ADDR = 16'hFFF1;
  localparam logic [7:0] SYSCTL_ONE_RESET = 8'h07;
  localparam logic [7:0] SYSCTL_TWO_RESET = 8'hE0;
  localparam logic [7:0] SYSCTL_ONE_FIXED = 8'h04;
  localparam logic [7:0] SYSCTL_TWO_FIXED = 8'hE0;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // Field positions, register one
  localparam int STBY_BIT = 7;
  localparam int SETTLE_HI = 6;
  localparam int SETTLE_LO = 4;
  localparam int LOWSPD_BIT = 3;
  localparam int MDIV_HI = 1;
  localparam int MDIV_LO = 0;
  // Field positions, register two
  localparam int NOISE_BIT = 4;
  localparam int DIRECT_BIT = 3;
  localparam int MEDSPD_BIT = 2;
  localparam int SDIV_HI = 1;
  localparam int SDIV_LO = 0;
  // Settling waits in states
  localparam int SETTLE_W = 18;
  localparam logic [17:0] SETTLE_0 = 18'h02000;
  localparam logic [17:0] SETTLE_1 = 18'h04000;
  localparam logic [17:0] SETTLE_2 = 18'h08000;
  localparam logic [17:0] SETTLE_3 = 18'h10000;
  localparam logic [17:0] SETTLE_4 = 18'h20000;
  // Divider ratio log2 values
  localparam logic [2:0] MDIV_BASE_LOG2 = 3'h4;
  localparam logic [1:0] SDIV_LOG2_8 = 2'h3;
  localparam logic [1:0] SDIV_LOG2_4 = 2'h2;
  localparam logic [1:0] SDIV_LOG2_2 = 2'h1;
  localparam logic [2:0] NOISE_LOG2_16 = 3'h4;
  localparam logic [2:0] NOISE_LOG2_4 = 3'h2;

  typedef enum logic [3:0] {
    MODE_ACT_HIGH = 4'h0,
    MODE_ACT_MED = 4'h1,
    MODE_SUBACT = 4'h2,
    MODE_SLP_HIGH = 4'h3,
    MODE_SLP_MED = 4'h4,
    MODE_SUBSLP = 4'h5,
    MODE_WATCH = 4'h6,
    MODE_STANDBY = 4'h7,
    MODE_SETTLE = 4'h8
  } power_mode_e;
endpackage

// >>> hw/power_mode_control_regs.sv
// Power mode sequencer with its two system control registers
//
// The implementer's own choice: strobed register access.
module power_mode_control_regs
  import power_mode_pkg::*;
#(
  parameter int SETTLE_SCALE = 1
)(
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [ADDR_W-1:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, cycle after strobe
  input wire logic sleep_exec, // Sleep instruction executed, pulse
  input wire logic timer_watch_select, // Timer watch bit level
  input wire logic wake_irq, // Enabled interrupt request level
  input wire logic cpu_irq_mask, // CPU interrupt mask bit
  output logic [3:0] op_mode, // Current operating mode
  output logic cpu_halt, // CPU halted
  output logic periph_hold, // Peripherals held idle
  output logic sys_osc_run, // System oscillator enabled
  output logic cpu_on_subclock, // CPU clock is subclock
  output logic [2:0] med_div_log2, // Medium-speed divide, log2
  output logic [1:0] sub_div_log2, // Subactive divide, log2
  output logic [2:0] noise_div_log2, // Noise sampling divide, log2
  output logic osc_div_en, // Medium-speed clock enable pulse
  output logic noise_sample_en // Watch clock sample enable pulse
);
  // Scale above 16 is rejected; at 16 the shortest wait is 512 cycles
  if (SETTLE_SCALE < 1 || SETTLE_SCALE > 16)
  begin : g_bad_scale
    $error("SETTLE_SCALE out of range");
  end

  logic [7:0] sys_one_r;
  logic [7:0] sys_two_r;
  power_mode_e mode_r;
  power_mode_e mode_nxt;
  power_mode_e settle_dest_r;
  logic [SETTLE_W-1:0] settle_cnt_r;
  logic [SETTLE_W-1:0] settle_len;
  logic [6:0] div_cnt_r;
  logic [7:0] rdata_r;
  logic wake_ok;
  logic stby;
  logic lowspd;
  logic medspd;
  logic direct;
  logic in_active;

  assign stby = sys_one_r[STBY_BIT];
  assign lowspd = sys_one_r[LOWSPD_BIT];
  assign medspd = sys_two_r[MEDSPD_BIT];
  assign direct = sys_two_r[DIRECT_BIT];
  assign in_active = (mode_r == MODE_ACT_HIGH) || (mode_r == MODE_ACT_MED);
  assign wake_ok = wake_irq && !cpu_irq_mask;

  // Register one; bit 2 stays fixed at one
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sys_one_r <= SYSCTL_ONE_RESET;
    else if (reg_wr && reg_addr == SYSCTL_ONE_ADDR)
      sys_one_r <= reg_wdata | SYSCTL_ONE_FIXED;
  end

  // Register two; divider field locked while in subactive
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sys_two_r <= SYSCTL_TWO_RESET;
    else if (reg_wr && reg_addr == SYSCTL_TWO_ADDR)
    begin
      sys_two_r[7:SDIV_HI+1] <= reg_wdata[7:SDIV_HI+1] | SYSCTL_TWO_FIXED[7:SDIV_HI+1];
      if (mode_r != MODE_SUBACT)
        sys_two_r[SDIV_HI:SDIV_LO] <= reg_wdata[SDIV_HI:SDIV_LO];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata_r <= RD_UNMAPPED;
    else if (reg_rd)
    begin
      if (reg_addr == SYSCTL_ONE_ADDR)
        rdata_r <= sys_one_r | SYSCTL_ONE_FIXED;
      else if (reg_addr == SYSCTL_TWO_ADDR)
        rdata_r <= sys_two_r | SYSCTL_TWO_FIXED;
      else
        rdata_r <= RD_UNMAPPED;
    end
  end
  assign reg_rdata = rdata_r;

  // Settling length; scale only shortens simulation
  always_comb
  begin
    unique casez (sys_one_r[SETTLE_HI:SETTLE_LO])
      3'b000: settle_len = SETTLE_0;
      3'b001: settle_len = SETTLE_1;
      3'b010: settle_len = SETTLE_2;
      3'b011: settle_len = SETTLE_3;
      default: settle_len = SETTLE_4;
    endcase
    settle_len = settle_len / SETTLE_W'(SETTLE_SCALE);
  end

  function automatic power_mode_e active_pick(input logic med);
    return med ? MODE_ACT_MED : MODE_ACT_HIGH;
  endfunction

  always_comb
  begin
    mode_nxt = mode_r;
    unique case (mode_r)
      MODE_ACT_HIGH, MODE_ACT_MED:
      begin
        if (sleep_exec)
        begin
          if (direct && !stby && !lowspd && (medspd != (mode_r == MODE_ACT_MED)))
            mode_nxt = active_pick(medspd);
          else if (direct && stby && timer_watch_select && lowspd)
            mode_nxt = MODE_SUBACT;
          else if (!stby)
            mode_nxt = medspd ? MODE_SLP_MED : MODE_SLP_HIGH;
          else if (timer_watch_select)
            mode_nxt = MODE_WATCH;
          else if (!lowspd)
            mode_nxt = MODE_STANDBY;
        end
      end
      MODE_SUBACT:
      begin
        if (sleep_exec)
        begin
          if (direct && stby && timer_watch_select && !lowspd)
            mode_nxt = active_pick(medspd);
          else if (!stby)
            mode_nxt = MODE_SUBSLP;
          else
            mode_nxt = MODE_WATCH;
        end
      end
      MODE_SLP_HIGH, MODE_SLP_MED:
        if (wake_ok)
          mode_nxt = active_pick(medspd);
      MODE_SUBSLP:
        if (wake_ok)
          mode_nxt = MODE_SUBACT;
      MODE_WATCH:
        if (wake_ok)
          mode_nxt = lowspd ? MODE_SUBACT : MODE_SETTLE;
      MODE_STANDBY:
        if (wake_ok)
          mode_nxt = MODE_SETTLE;
      MODE_SETTLE:
        if (settle_cnt_r == '0)
          mode_nxt = settle_dest_r;
      default:
        mode_nxt = MODE_ACT_HIGH;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      mode_r <= MODE_ACT_HIGH;
    else
      mode_r <= mode_nxt;
  end

  // Destination latched at wake so a later write cannot redirect it
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      settle_dest_r <= MODE_ACT_HIGH;
    else if (mode_r != MODE_SETTLE && mode_nxt == MODE_SETTLE)
      settle_dest_r <= active_pick(medspd);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      settle_cnt_r <= '0;
    else if (mode_r != MODE_SETTLE && mode_nxt == MODE_SETTLE)
      settle_cnt_r <= settle_len - SETTLE_W'(1);
    else if (mode_r == MODE_SETTLE && settle_cnt_r != '0)
      settle_cnt_r <= settle_cnt_r - SETTLE_W'(1);
  end

  // Free-running divider for the derived enables
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      div_cnt_r <= '0;
    else
      div_cnt_r <= div_cnt_r + 7'h01;
  end

  always_comb
  begin
    logic [2:0] mlog;
    logic [6:0] mmask;
    logic [6:0] nmask;
    mlog = MDIV_BASE_LOG2 + {1'b0, sys_one_r[MDIV_HI:MDIV_LO]};
    mmask = 7'(({7'h00, 1'b1} << mlog) - 8'h01);
    nmask = sys_two_r[NOISE_BIT] ? 7'h03 : 7'h0F;
    med_div_log2 = mlog;
    noise_div_log2 = sys_two_r[NOISE_BIT] ? NOISE_LOG2_4 : NOISE_LOG2_16;
    osc_div_en = (div_cnt_r & mmask) == 7'h00;
    noise_sample_en = (div_cnt_r & nmask) == 7'h00;
  end

  always_comb
  begin
    unique casez (sys_two_r[SDIV_HI:SDIV_LO])
      2'b00: sub_div_log2 = SDIV_LOG2_8;
      2'b01: sub_div_log2 = SDIV_LOG2_4;
      default: sub_div_log2 = SDIV_LOG2_2;
    endcase
  end

  // Status outputs for clock generator and halt logic
  assign op_mode = mode_r;
  assign cpu_halt = !(in_active || mode_r == MODE_SUBACT);
  assign periph_hold = (mode_r == MODE_STANDBY) || (mode_r == MODE_SETTLE);
  assign sys_osc_run = !(mode_r == MODE_STANDBY || mode_r == MODE_WATCH ||
                         mode_r == MODE_SUBACT || mode_r == MODE_SUBSLP);
  assign cpu_on_subclock = (mode_r == MODE_SUBACT) || (mode_r == MODE_SUBSLP);
endmodule

// >>> verif/pm_chk.sv
// Port checker for the power mode block
module pm_chk
  import power_mode_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic [ADDR_W-1:0] reg_addr, // Address
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic wake_irq, // Wake request
  input wire logic cpu_irq_mask, // Wake mask
  input wire logic [3:0] op_mode, // Mode
  input wire logic [1:0] sub_div_log2, // Subactive divide
  input wire logic osc_div_en, // Medium pulse
  input wire logic noise_sample_en // Noise pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic pd;
  assign pd = op_mode inside {4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
  chk_fixed_one: assert property (reg_rd && reg_addr == 16'hFFF0 |=> reg_rdata[2])
    else $error("register one bit 2 low");
  chk_fixed_two: assert property (reg_rd && reg_addr == 16'hFFF1 |=> &reg_rdata[7:5])
    else $error("register two top bits low");
  chk_unmapped_read: assert property (reg_rd && reg_addr[15:1] != 15'h7FF8 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_mask_hold: assert property (pd && cpu_irq_mask |=> op_mode == $past(op_mode))
    else $error("masked wake left power-down");
  chk_stby_settle: assert property (op_mode == 4'h7 && wake_irq && !cpu_irq_mask
    |=> op_mode == 4'h8)
    else $error("standby wake skipped settle");
  chk_sleep_wake: assert property ((op_mode == 4'h3 || op_mode == 4'h4) && wake_irq
    && !cpu_irq_mask |=> op_mode == $past(op_mode) - 4'h3)
    else $error("sleep wake to wrong mode");
  chk_osc_gap: assert property (osc_div_en |=> !osc_div_en [*8])
    else $error("medium pulses too close");
  chk_noise_gap: assert property (noise_sample_en |=> !noise_sample_en [*3])
    else $error("noise pulses too close");
  chk_sub_div: assert property (sub_div_log2 != 2'h0)
    else $error("subactive divide code zero");
  cover property (op_mode == 4'h8 ##1 op_mode == 4'h0);
  cover property (pd && cpu_irq_mask && wake_irq);
  cover property (op_mode == 4'h2 ##1 op_mode == 4'h1);
endmodule

bind power_mode_control_regs pm_chk u_chk (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wake_irq(wake_irq), .cpu_irq_mask(cpu_irq_mask),
  .op_mode(op_mode), .sub_div_log2(sub_div_log2), .osc_div_en(osc_div_en),
  .noise_sample_en(noise_sample_en));

// >>> verif/cpu_model.sv
// Behavioural CPU: register bus master and sleep events
module cpu_model
  import power_mode_pkg::*;
(
  input wire logic clk, // Clock
  output logic [ADDR_W-1:0] reg_addr, // Address
  output logic [7:0] reg_wdata, // Write data
  output logic reg_wr, // Write strobe
  output logic reg_rd, // Read strobe
  output logic sleep_exec, // Sleep pulse
  output logic timer_watch_select, // Timer watch bit
  output logic wake_irq, // Wake request
  output logic cpu_irq_mask // Wake mask
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {sleep_exec, timer_watch_select, wake_irq, cpu_irq_mask} = '0;
  end
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    // Idle bus shows inverted values so stale data is not trusted
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask
  task automatic sleep_op(input logic t);
    @(posedge clk);
    timer_watch_select <= t;
    sleep_exec <= 1'b1;
    @(posedge clk);
    sleep_exec <= 1'b0;
  endtask
  task automatic wake_op(input logic m);
    @(posedge clk);
    cpu_irq_mask <= m;
    wake_irq <= 1'b1;
    @(posedge clk);
    wake_irq <= 1'b0;
  endtask
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the power mode block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import power_mode_pkg::*;
  logic clk, rst_n, reg_wr, reg_rd, sleep_exec, timer_watch_select, wake_irq, cpu_irq_mask;
  logic cpu_halt, periph_hold, sys_osc_run, cpu_on_subclock;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [3:0] op_mode;
  logic [2:0] med_div_log2, noise_div_log2;
  logic [1:0] sub_div_log2;
  logic [7:0] exp_q[$];
  logic rd_q = 1'b0;
  int err_count = 0, tests_run = 0, cycles = 0, seed, n;
  cpu_model cpu (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .sleep_exec(sleep_exec), .timer_watch_select(timer_watch_select),
    .wake_irq(wake_irq), .cpu_irq_mask(cpu_irq_mask));
  power_mode_control_regs #(.SETTLE_SCALE(16)) dut (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sleep_exec(sleep_exec), .timer_watch_select(timer_watch_select),
    .wake_irq(wake_irq), .cpu_irq_mask(cpu_irq_mask), .op_mode(op_mode),
    .cpu_halt(cpu_halt), .periph_hold(periph_hold), .sys_osc_run(sys_osc_run),
    .cpu_on_subclock(cpu_on_subclock), .med_div_log2(med_div_log2),
    .sub_div_log2(sub_div_log2), .noise_div_log2(noise_div_log2), .osc_div_en(),
    .noise_sample_en());
  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    cpu.bus(1'b0, a, 8'h00);
  endtask
  task automatic slp(input logic t, input logic [3:0] m);
    cpu.sleep_op(t);
    #1;
    check(18'(op_mode), 18'(m));
  endtask
  task automatic wk(input logic k, input logic [3:0] m);
    cpu.wake_op(k);
    #1;
    check(18'(op_mode), 18'(m));
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Read data is looked at only in the cycle after the strobe
  always @(posedge clk)
  begin
    if (rd_q && exp_q.size() > 0)
      check(18'(reg_rdata), 18'(exp_q.pop_front()));
    rd_q <= reg_rd;
    cycles++;
    if (cycles == 40000)
    begin
      err_count++;
      report_and_stop();
    end
  end
  initial
  begin
    rst_n = 1'b0;
    seed = 13;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(16'hFFF0, 8'h07);
    rd(16'hFFF1, 8'hE0);
    rd(16'hFFF2, 8'h00);
    repeat (4)
    begin
      d = 8'($random(seed));
      cpu.bus(1'b1, 16'hFFF0, d);
      rd(16'hFFF0, d | 8'h04);
      d = 8'($random(seed));
      cpu.bus(1'b1, 16'hFFF1, d);
      rd(16'hFFF1, d | 8'hE0);
    end
    cpu.bus(1'b1, 16'hFFF1, 8'h00);
    for (int k = 0; k < 5; k++)
    begin
      cpu.bus(1'b1, 16'hFFF0, {1'b1, (k == 4) ? 3'h6 : 3'(k), 4'h0});
      slp(1'b0, 4'h7);
      check(18'({cpu_halt, periph_hold, sys_osc_run, cpu_on_subclock}), 18'hC);
      wk(1'b1, 4'h7);
      wk(1'b0, 4'h8);
      check(18'({cpu_halt, periph_hold, sys_osc_run, cpu_on_subclock}), 18'hE);
      n = 0;
      while (op_mode === 4'h8 && n < 9000)
      begin
        @(posedge clk);
        #1;
        n++;
      end
      check(18'(n), 18'(512 << k));
      check(18'(op_mode), 18'h0);
    end
    check(18'(med_div_log2), 18'h4);
    cpu.bus(1'b1, 16'hFFF1, 8'h04);
    cpu.bus(1'b1, 16'hFFF0, 8'h03);
    check(18'(med_div_log2), 18'h7);
    slp(1'b0, 4'h4);
    wk(1'b0, 4'h1);
    cpu.bus(1'b1, 16'hFFF1, 8'h08);
    slp(1'b0, 4'h0);
    cpu.bus(1'b1, 16'hFFF1, 8'h0C);
    slp(1'b0, 4'h1);
    cpu.bus(1'b1, 16'hFFF0, 8'h8B);
    slp(1'b1, 4'h2);
    check(18'({cpu_halt, periph_hold, sys_osc_run, cpu_on_subclock}), 18'h1);
    cpu.bus(1'b1, 16'hFFF1, 8'h0E);
    rd(16'hFFF1, 8'hEC);
    check(18'(sub_div_log2), 18'h3);
    cpu.bus(1'b1, 16'hFFF0, 8'h83);
    slp(1'b1, 4'h1);
    cpu.bus(1'b1, 16'hFFF1, 8'h10);
    check(18'(noise_div_log2), 18'h2);
    cpu.bus(1'b1, 16'hFFF0, 8'h8B);
    slp(1'b1, 4'h6);
    wk(1'b0, 4'h2);
    cpu.bus(1'b1, 16'hFFF0, 8'h0B);
    slp(1'b1, 4'h5);
    check(18'({cpu_halt, periph_hold, sys_osc_run, cpu_on_subclock}), 18'h9);
    report_and_stop();
  end
endmodule
